// [rtl/core_regs_params.svh]
// Offsets, field positions, reset values and bank layout of the core status and pointer registers
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH
`define ADDR_STACK_POINTER 8'h81
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_PROGRAM_STATUS_WORD 8'hD0
`define ADDR_PRIMARY_OPERAND 8'hE0
`define ADDR_SECOND_OPERAND 8'hF0
`define RST_STACK_POINTER 8'h07
`define RST_DATA_POINTER_LOW 8'h00
`define RST_DATA_POINTER_HIGH 8'h00
`define RST_PROGRAM_STATUS_WORD 8'h00
`define RST_PRIMARY_OPERAND 8'h00
`define RST_SECOND_OPERAND 8'h00
`define BIT_CARRY 3'd7
`define BIT_HALF_CARRY 3'd6
`define BIT_USER_ZERO 3'd5
`define BIT_BANK_HIGH 3'd4
`define BIT_BANK_LOW 3'd3
`define BIT_SIGNED_RANGE 3'd2
`define BIT_USER_ONE 3'd1
`define BIT_PARITY 3'd0
`define STATUS_SW_MASK 8'hFE
`define BANK_SIZE_SHIFT 3
`define BIT_ADDR_LOW_NIBBLE_MASK 8'h07
`endif

// [rtl/core_regs_pkg.sv]
// Types shared by the core status and pointer registers
`default_nettype none
package core_regs_pkg;
  // Access from the instruction datapath
  typedef struct packed {
    logic wr_byte;
    logic wr_bit;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;
  // Flag update from the arithmetic unit
  typedef struct packed {
    logic upd;
    logic carry;
    logic half_carry;
    logic signed_range;
  } flag_upd_s;
  // Stack operations
  typedef enum logic [1:0] {
    STK_NONE = 2'b00,
    STK_PUSH = 2'b01,
    STK_POP = 2'b10
  } stack_op_e;
endpackage
`default_nettype wire

// [rtl/parity_calc.sv]
// Even-parity generator over a byte of configurable width
`default_nettype none
module parity_calc #(
  parameter int WIDTH = 8
) (
  // Data in
  input wire logic [WIDTH-1:0] data,
  // Parity out
  output logic parity
);
  initial begin
    if (WIDTH < 1) $error("parity_calc: WIDTH must be positive");
  end
  // Bit is one when the data holds an odd number of ones
  assign parity = ^data;
endmodule
`default_nettype wire

// [rtl/core_status_pointer_registers.sv]
// Core status, pointer and operand registers of the processor
//
// Contract
// RULE_01: Unassigned addresses such as 0x97, 0xCE and 0xDF hold no register; writes are dropped and reads give zero.
// RULE_02: Software should never write a one into a reserved bit position.
// RULE_03: Any reserved bit resets to zero, with zero selecting the default behaviour.
// RULE_04: The low pointer byte is a read-write byte at 0x82 resetting to zero, lower half of the 16-bit pointer.
// RULE_05: The high pointer byte is a byte at 0x83 forming the upper half of the 16-bit pointer.
// RULE_06: The status word sits at 0xD0, resets to zero, is bit addressable, bits 7 to 1 writable, bit 0 read-only.
// RULE_07: The half-carry flag is set on a nibble carry or borrow and cleared by other arithmetic operations.
// RULE_08: The two user flags in bits 5 and 1 change only through software writes.
// RULE_09: The primary operand register is a read-write bit-addressable byte at 0xE0 resetting to zero.
// RULE_10: The second operand register is a read-write byte at 0xF0.
// RULE_11: Status bits 4 and 3 select one of four eight-byte banks at 8n to 8n+7.
// RULE_12: The stack pointer at 0x81 resets to 0x07 and a push increments before writing.
// RULE_13: Registers at addresses ending in 0x0 or 0x8 accept bit writes; the rest are byte only.
// RULE_14: Carry and signed-range flags follow the last arithmetic operation and are cleared by others.
// RULE_15: The parity bit always reflects even parity of the primary operand register.
`include "core_regs_params.svh"
`default_nettype none
module core_status_pointer_registers (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the datapath
  input wire core_regs_pkg::sfr_req_s req,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Arithmetic flags, operand results and stack
  input wire core_regs_pkg::flag_upd_s flags,
  input wire logic operand_load,
  input wire logic [7:0] operand_value,
  input wire logic second_load,
  input wire logic [7:0] second_value,
  input wire core_regs_pkg::stack_op_e stack_op,
  // Register contents for the datapath
  output logic [7:0] stack_pointer,
  output logic [7:0] push_addr,
  output logic [15:0] data_pointer,
  output logic [7:0] program_status_word,
  output logic [7:0] primary_operand,
  output logic [7:0] second_operand,
  output logic [4:0] bank_base
);
  import core_regs_pkg::*;

  // Architectural registers and their next values
  logic [7:0] stack_ff, nxt_stack;
  logic [7:0] ptr_lo_ff, nxt_ptr_lo;
  logic [7:0] ptr_hi_ff, nxt_ptr_hi;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] operand_ff, nxt_operand;
  logic [7:0] second_ff, nxt_second;
  // Registered read port and push address
  logic [7:0] rd_ff, nxt_rd;
  logic [7:0] push_ff, nxt_push;
  // Decoded access qualifiers and the parity of the next operand
  logic bit_ok;
  logic hit_wr;
  logic parity_now;

  // Parity of the next operand value so the stored bit never lags the register
  parity_calc #(.WIDTH(8)) u_parity (
    .data(nxt_operand),
    .parity(parity_now)
  );

  // Bit writes only reach addresses with low nibble 0 or 8
  assign bit_ok = req.wr_bit && ((req.addr & `BIT_ADDR_LOW_NIBBLE_MASK) == 8'h00); // see RULE_13
  // Limitation: a refused bit strobe is dropped silently, there is no error flag for software
  assign hit_wr = req.wr_byte || bit_ok;

  // Merges a byte or bit write into a register value
  // Bit writes read the current value, so only the selected bit moves
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd, input logic bw,
                                       input logic [2:0] bs);
    logic [7:0] r;
    r = cur;
    if (bw) begin
      r[bs] = wd[0];
    end else begin
      r = wd;
    end
    return r;
  endfunction

  // Next state of all registers; a software write wins over a hardware update in the same cycle
  // Giving software the last word keeps a status restore exact even if a flag pulse lands with it,
  // at the price of losing that pulse
  always_comb begin
    nxt_stack = stack_ff;
    nxt_ptr_lo = ptr_lo_ff;
    nxt_ptr_hi = ptr_hi_ff;
    nxt_status = status_ff;
    nxt_operand = operand_ff;
    nxt_second = second_ff;
    // Stack pointer moves before the push data is written
    case (stack_op)
      STK_PUSH: nxt_stack = stack_ff + 8'h01; // see RULE_12
      STK_POP: nxt_stack = stack_ff - 8'h01;
      default: nxt_stack = stack_ff;
    endcase
    // Datapath results land unless software writes the same register
    if (operand_load) begin
      nxt_operand = operand_value;
    end
    if (second_load) begin
      nxt_second = second_value;
    end
    // Arithmetic flags; user flags and bank bits are left alone by hardware
    if (flags.upd) begin
      nxt_status[`BIT_CARRY] = flags.carry; // see RULE_14
      nxt_status[`BIT_SIGNED_RANGE] = flags.signed_range; // see RULE_14
      nxt_status[`BIT_HALF_CARRY] = flags.half_carry; // see RULE_07
    end
    if (hit_wr) begin
      // Only the six documented addresses decode; all others are dropped
      case (req.addr)
        `ADDR_STACK_POINTER: if (!req.wr_bit) nxt_stack = req.wdata; // see RULE_12
        `ADDR_DATA_POINTER_LOW: if (!req.wr_bit) nxt_ptr_lo = req.wdata; // see RULE_04
        `ADDR_DATA_POINTER_HIGH: if (!req.wr_bit) nxt_ptr_hi = req.wdata; // see RULE_05
        `ADDR_PROGRAM_STATUS_WORD: begin
          // Parity is read-only; bits 7 to 1 take the write, user flags only change here
          nxt_status = (merge(status_ff, req.wdata, bit_ok, bit_sel) & `STATUS_SW_MASK) |
                       (nxt_status & ~`STATUS_SW_MASK); // see RULE_06, see RULE_08
        end
        `ADDR_PRIMARY_OPERAND: nxt_operand = merge(operand_ff, req.wdata, bit_ok, bit_sel); // see RULE_09
        `ADDR_SECOND_OPERAND: nxt_second = merge(second_ff, req.wdata, bit_ok, bit_sel); // see RULE_10
        default: nxt_operand = nxt_operand; // see RULE_01
      endcase
    end
    nxt_status[`BIT_PARITY] = parity_now; // see RULE_15
  end

  // Read mux; unmapped addresses return zero
  // Reading the next values gives the post-update contents one cycle after the address
  always_comb begin
    case (rd_addr)
      `ADDR_STACK_POINTER: nxt_rd = nxt_stack;
      `ADDR_DATA_POINTER_LOW: nxt_rd = nxt_ptr_lo;
      `ADDR_DATA_POINTER_HIGH: nxt_rd = nxt_ptr_hi;
      `ADDR_PROGRAM_STATUS_WORD: nxt_rd = nxt_status;
      `ADDR_PRIMARY_OPERAND: nxt_rd = nxt_operand;
      `ADDR_SECOND_OPERAND: nxt_rd = nxt_second;
      default: nxt_rd = 8'h00; // see RULE_01
    endcase
    // Push address follows the pointer after its increment
    nxt_push = nxt_stack;
  end

  // Register stage; all control state resets to defined values
  // Parity resets to zero, which matches the zero operand it describes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_ff <= `RST_STACK_POINTER; // see RULE_12
      ptr_lo_ff <= `RST_DATA_POINTER_LOW; // see RULE_04
      ptr_hi_ff <= `RST_DATA_POINTER_HIGH;
      status_ff <= `RST_PROGRAM_STATUS_WORD; // see RULE_03, see RULE_06
      operand_ff <= `RST_PRIMARY_OPERAND; // see RULE_09
      second_ff <= `RST_SECOND_OPERAND;
      rd_ff <= 8'h00;
      push_ff <= `RST_STACK_POINTER;
    end else begin
      stack_ff <= nxt_stack;
      ptr_lo_ff <= nxt_ptr_lo;
      ptr_hi_ff <= nxt_ptr_hi;
      status_ff <= nxt_status;
      operand_ff <= nxt_operand;
      second_ff <= nxt_second;
      rd_ff <= nxt_rd;
      push_ff <= nxt_push;
    end
  end

  // Outputs come straight from flip-flops
  assign stack_pointer = stack_ff;
  // Address of the byte a push just wrote
  assign push_addr = push_ff;
  assign data_pointer = {ptr_hi_ff, ptr_lo_ff}; // see RULE_04, see RULE_05
  assign program_status_word = status_ff;
  assign primary_operand = operand_ff;
  assign second_operand = second_ff;
  assign rd_data = rd_ff;
  // Bank n base is 8n inside 0x00 to 0x1F
  assign bank_base = {status_ff[`BIT_BANK_HIGH], status_ff[`BIT_BANK_LOW], 3'b000}; // see RULE_11

  // Checks
  // Checks with |=> look at the cycle after the request, when the register stage has taken it; the reset, parity and bank checks look at the same cycle
  // Antecedents leave out same-cycle software writes, which win by design
  // Named steps used by the checks; only s_push_alone is shared, by two of them
  sequence s_push_alone;
    stack_op == STK_PUSH && !hit_wr;
  endsequence

  sequence s_pop_alone;
    stack_op == STK_POP && !hit_wr;
  endsequence

  sequence s_operand_bit;
    req.wr_bit && !req.wr_byte && req.addr == `ADDR_PRIMARY_OPERAND;
  endsequence

  sequence s_reserved_write;
    req.wr_byte && !req.wr_bit && req.addr == 8'h97 && !operand_load && !second_load && !flags.upd &&
      stack_op == STK_NONE;
  endsequence

  // Stack pointer steps by one on a lone push or pop
  property p_stack_push;
    @(posedge clk) disable iff (!rst_n)
      s_push_alone |=> (stack_ff == $past(stack_ff) + 8'h01);
  endproperty
  push_increments_a: assert property (p_stack_push) else $error("push did not increment pointer"); // see RULE_12
  pop_decrements_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
    s_pop_alone |=> stack_ff == $past(stack_ff) - 8'h01)
    else $error("pop did not decrement pointer");
  push_address_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
    s_push_alone |=> push_addr == $past(stack_ff) + 8'h01)
    else $error("push address is not the incremented pointer");
  stack_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
    (req.wr_byte && !req.wr_bit && req.addr == `ADDR_STACK_POINTER) |=> stack_pointer == $past(req.wdata))
    else $error("pointer write lost");

  // Reset leaves the documented values behind
  reset_pointer_a: assert property (@(posedge clk) // see RULE_12
    $rose(rst_n) |-> stack_ff == 8'h07 && operand_ff == 8'h00)
    else $error("pointer reset value wrong");
  reset_values_a: assert property (@(posedge clk) // see RULE_04
    $rose(rst_n) |-> data_pointer == 16'h0000 && program_status_word == 8'h00)
    else $error("pointer or status reset value wrong");

  // Parity and flag bits of the status word
  parity_tracks_a: assert property (@(posedge clk) disable iff (!rst_n) status_ff[0] == ^operand_ff) // see RULE_15
    else $error("parity does not match operand");
  user_flags_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_08
    !(hit_wr && req.addr == `ADDR_PROGRAM_STATUS_WORD) |=> $stable({status_ff[5], status_ff[1]}))
    else $error("user flag changed without write");
  half_carry_upd_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_07
    (flags.upd && !(hit_wr && req.addr == `ADDR_PROGRAM_STATUS_WORD)) |=>
      status_ff[6] == $past(flags.half_carry))
    else $error("half carry not updated");
  carry_upd_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
    (flags.upd && !(hit_wr && req.addr == `ADDR_PROGRAM_STATUS_WORD)) |=>
      status_ff[7] == $past(flags.carry) && status_ff[2] == $past(flags.signed_range))
    else $error("carry or range flag not updated");
  status_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
    (req.wr_byte && !req.wr_bit && req.addr == `ADDR_PROGRAM_STATUS_WORD) |=>
      program_status_word[7:1] == $past(req.wdata[7:1]))
    else $error("status write lost");

  // Pointer bytes and byte-only refusal
  ptr_low_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
    (req.wr_byte && !req.wr_bit && req.addr == `ADDR_DATA_POINTER_LOW) |=> data_pointer[7:0] == $past(req.wdata))
    else $error("low pointer write lost");
  ptr_high_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_05
    (req.wr_byte && !req.wr_bit && req.addr == `ADDR_DATA_POINTER_HIGH) |=> data_pointer[15:8] == $past(req.wdata))
    else $error("high pointer write lost");
  no_bit_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_13
    (req.wr_bit && !req.wr_byte && req.addr == `ADDR_DATA_POINTER_LOW) |=> $stable(ptr_lo_ff))
    else $error("bit write reached byte-only register");
  stack_no_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_13
    (req.wr_bit && !req.wr_byte && req.addr == `ADDR_STACK_POINTER && stack_op == STK_NONE) |=> $stable(stack_ff))
    else $error("bit write reached stack pointer");

  // Operand registers
  operand_load_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_09
    (operand_load && !(hit_wr && req.addr == `ADDR_PRIMARY_OPERAND)) |=>
      primary_operand == $past(operand_value))
    else $error("operand load lost");
  second_load_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_10
    (second_load && !(hit_wr && req.addr == `ADDR_SECOND_OPERAND)) |=>
      second_operand == $past(second_value))
    else $error("second operand load lost");
  operand_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_13
    s_operand_bit |=>
      ((primary_operand >> $past(bit_sel)) & 8'h01) == {7'h00, $past(req.wdata[0])})
    else $error("operand bit write lost");

  // Read port, reserved space and bank base
  reserved_read_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_01
    (rd_addr == 8'h97 || rd_addr == 8'hCE || rd_addr == 8'hDF) |=> rd_data == 8'h00)
    else $error("reserved address read nonzero");
  reserved_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_01
    s_reserved_write |=>
      $stable({stack_ff, ptr_hi_ff, ptr_lo_ff, status_ff, operand_ff, second_ff}))
    else $error("reserved write changed a register");
  status_read_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
    rd_addr == `ADDR_PROGRAM_STATUS_WORD |=> rd_data == program_status_word)
    else $error("status read mismatch");
  second_read_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_10
    rd_addr == `ADDR_SECOND_OPERAND |=> rd_data == second_operand)
    else $error("second operand read mismatch");
  ptr_read_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
    rd_addr == `ADDR_DATA_POINTER_LOW |=> rd_data == data_pointer[7:0])
    else $error("low pointer read mismatch");
  stack_read_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
    rd_addr == `ADDR_STACK_POINTER |=> rd_data == stack_pointer)
    else $error("stack pointer read mismatch");
  bank_map_a: assert property (@(posedge clk) disable iff (!rst_n) bank_base == {status_ff[4:3], 3'b000}) // see RULE_11
    else $error("bank base mismatch");
endmodule
`default_nettype wire

// [verification/datapath_model.sv]
// Behavioural model of the instruction datapath that drives the core registers
`default_nettype none
module datapath_model (
  // Clock
  input wire logic clk,
  // Register access
  output var core_regs_pkg::sfr_req_s req,
  output var logic [2:0] bit_sel,
  output var logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Arithmetic results and stack
  output var core_regs_pkg::flag_upd_s flags,
  output var logic operand_load,
  output var logic [7:0] operand_value,
  output var logic second_load,
  output var logic [7:0] second_value,
  output var core_regs_pkg::stack_op_e stack_op
);
  timeunit 1ns;
  timeprecision 1ns;
  import core_regs_pkg::*;
  // Idle values before the first edge
  initial begin
    req = '0;
    bit_sel = 3'h0;
    rd_addr = 8'h00;
    flags = '0;
    operand_load = 1'b0;
    operand_value = 8'h00;
    second_load = 1'b0;
    second_value = 8'h00;
    stack_op = STK_NONE;
  end
  // One-cycle write; released lines carry inverted data so a stale value is never trusted
  task automatic wr(input logic bitw, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
    @(posedge clk);
    req <= '{~bitw, bitw, a, d};
    bit_sel <= b;
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
  endtask
  // Read data is registered one cycle behind the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1;
    d = rd_data;
  endtask
  // Flag pulse at the end of an arithmetic operation
  task automatic arith(input logic c, input logic h, input logic s);
    @(posedge clk);
    flags <= '{1'b1, c, h, s};
    @(posedge clk);
    flags <= '{1'b0, ~c, ~h, ~s};
    #1;
  endtask
  // Result load into the primary operand
  task automatic ld(input logic [7:0] v);
    @(posedge clk);
    operand_load <= 1'b1;
    operand_value <= v;
    @(posedge clk);
    operand_load <= 1'b0;
    operand_value <= ~v;
    #1;
  endtask
  // Result load into the second operand
  task automatic ldb(input logic [7:0] v);
    @(posedge clk);
    second_load <= 1'b1;
    second_value <= v;
    @(posedge clk);
    second_load <= 1'b0;
    second_value <= ~v;
    #1;
  endtask
  // Single push or pop
  task automatic stk(input stack_op_e op);
    @(posedge clk);
    stack_op <= op;
    @(posedge clk);
    stack_op <= STK_NONE;
    #1;
  endtask
endmodule
`default_nettype wire

// [verification/core_status_pointer_registers_tb_top.sv]
// Self-checking testbench of the core status and pointer registers
`default_nettype none
module core_status_pointer_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import core_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sfr_req_s req;
  flag_upd_s flags;
  stack_op_e stack_op;
  logic [2:0] bit_sel;
  logic [7:0] rd_addr, rd_data, operand_value, second_value, stk_ptr, push_addr, status, operand, second;
  logic [15:0] data_pointer;
  logic [4:0] bank_base;
  logic operand_load, second_load;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  core_status_pointer_registers dut_u (.clk(clk), .rst_n(rst_n), .req(req), .bit_sel(bit_sel),
    .rd_addr(rd_addr), .rd_data(rd_data), .flags(flags), .operand_load(operand_load),
    .operand_value(operand_value), .second_load(second_load), .second_value(second_value),
    .stack_op(stack_op), .stack_pointer(stk_ptr), .push_addr(push_addr),
    .data_pointer(data_pointer), .program_status_word(status), .primary_operand(operand),
    .second_operand(second), .bank_base(bank_base));
  datapath_model m (.clk(clk), .req(req), .bit_sel(bit_sel), .rd_addr(rd_addr), .rd_data(rd_data),
    .flags(flags), .operand_load(operand_load), .operand_value(operand_value), .second_load(second_load),
    .second_value(second_value), .stack_op(stack_op));
  // 50 ns period
  always #25 clk = ~clk;
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Ceiling well above the 73 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  task automatic t_reset();
    chk8("stack_pointer", 8'h07, stk_ptr);
    chk8("data_pointer_high", 8'h00, data_pointer[15:8]);
    chk8("data_pointer_low", 8'h00, data_pointer[7:0]);
    chk8("status", 8'h00, status);
    chk8("operand", 8'h00, operand);
    $display("reset test done");
  endtask
  task automatic t_bytes();
    logic [7:0] good[5] = '{8'h81, 8'h82, 8'h83, 8'hE0, 8'hF0};
    logic [7:0] bad[3] = '{8'h97, 8'hCE, 8'hDF};
    logic [7:0] d;
    foreach (good[i]) begin
      m.wr(1'b0, good[i], good[i] ^ 8'h5A, 3'h0);
      m.rd(good[i], d);
      chk8("readback", good[i] ^ 8'h5A, d);
    end
    chk8("data_pointer_high", 8'hD9, data_pointer[15:8]);
    chk8("second", 8'hAA, second);
    foreach (bad[i]) begin
      m.wr(1'b0, bad[i], 8'hFF, 3'h0);
      m.rd(bad[i], d);
      chk8("unmapped", 8'h00, d);
    end
    $display("byte test done");
  endtask
  task automatic t_status();
    m.ld(8'h03);
    chk8("status", 8'h00, status);
    m.wr(1'b0, 8'hD0, 8'hFF, 3'h0);
    chk8("status", 8'hFE, status);
    chk8("bank_base", 8'h18, {3'h0, bank_base});
    m.ld(8'h07);
    chk8("status", 8'hFF, status);
    m.arith(1'b0, 1'b0, 1'b0);
    chk8("status", 8'h3B, status);
    m.arith(1'b1, 1'b1, 1'b1);
    chk8("status", 8'hFF, status);
    m.wr(1'b1, 8'hD0, 8'h00, 3'h5);
    chk8("status", 8'hDF, status);
    m.wr(1'b1, 8'h82, 8'h01, 3'h0);
    chk8("data_pointer_low", 8'hD8, data_pointer[7:0]);
    m.wr(1'b0, 8'hD0, 8'h08, 3'h0);
    chk8("bank_base", 8'h08, {3'h0, bank_base});
    $display("status test done");
  endtask
  task automatic t_stack();
    m.wr(1'b0, 8'h81, 8'h07, 3'h0);
    m.stk(STK_PUSH);
    chk8("stack_pointer", 8'h08, stk_ptr);
    chk8("push_addr", 8'h08, push_addr);
    m.stk(STK_POP);
    chk8("stack_pointer", 8'h07, stk_ptr);
    m.wr(1'b1, 8'h81, 8'h01, 3'h0);
    chk8("stack_pointer", 8'h07, stk_ptr);
    $display("stack test done");
  endtask
  task automatic t_second();
    logic [7:0] d;
    m.ldb(8'h3C);
    chk8("second", 8'h3C, second);
    m.rd(8'hF0, d);
    chk8("second_read", 8'h3C, d);
    m.wr(1'b1, 8'hE0, 8'h01, 3'h4);
    chk8("operand", 8'h17, operand);
    m.rd(8'hD0, d);
    chk8("status_read", 8'h08, d);
    $display("second operand test done");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_bytes();
    t_status();
    t_second();
    t_stack();
    test_done();
  end
endmodule
`default_nettype wire
